// ### src/iosp_top.v
// Low I/O register space: decode, port latches, flag registers and scratch bytes.
`timescale 1ns/1ps
`include "iosp_consts.vh"
module iosp_top (
    input wire clk_i,
    input wire rstn_i,
    input wire io_rd_i,
    input wire io_wr_i,
    input wire [5:0] io_addr_i,
    input wire load_op_i,
    input wire memory_write_op_i,
    input wire [7:0] data_addr_i,
    input wire bit_set_op_i,
    input wire bit_clear_op_i,
    input wire skip_if_bit_set_i,
    input wire skip_if_bit_clear_i,
    input wire [4:0] bit_addr_i,
    input wire [2:0] bit_sel_i,
    input wire [7:0] wdata_i,
    input wire [7:0] pad_b_i,
    input wire [7:0] pad_c_i,
    input wire [7:0] pad_d_i,
    input wire [2:0] pad_e_i,
    input wire [7:0] timer0_set_i,
    input wire [7:0] timer1_set_i,
    input wire [7:0] pad_change_set_i,
    output reg [7:0] rdata_o,
    output reg skip_o,
    output reg ext_sel_o,
    output reg [7:0] direction_b_o,
    output reg [7:0] drive_latch_b_o,
    output reg [7:0] direction_c_o,
    output reg [7:0] drive_latch_c_o,
    output reg [7:0] direction_d_o,
    output reg [7:0] drive_latch_d_o,
    output reg [7:0] direction_e_o,
    output reg [7:0] drive_latch_e_o,
    output reg [7:0] timer0_flags_o,
    output reg [7:0] timer1_flags_o,
    output reg [7:0] pad_change_flags_o
);
    // ----------------------------------------------------------------
    // Reset release and pad synchronisers.
    // ----------------------------------------------------------------
    reg rst_meta;
    reg rst_n;
    wire [7:0] lvl_b;
    wire [7:0] lvl_c;
    wire [7:0] lvl_d;
    wire [7:0] lvl_e;
    reg [7:0] scratch_1;
    reg [7:0] scratch_2;

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    iosp_sync #(.WIDTH(32)) u_sync (
        .clk_i(clk_i),
        .rstn_i(rst_n),
        .async_i({5'h00, pad_e_i, pad_d_i, pad_c_i, pad_b_i}),
        .sync_o({lvl_e, lvl_d, lvl_c, lvl_b})
    );

    // ----------------------------------------------------------------
    // Address decode.
    // ----------------------------------------------------------------
    reg wr_en;
    reg rd_en;
    reg [5:0] acc_addr;
    reg [7:0] data_io;
    reg bit_op;
    reg [7:0] bit_mask;
    reg [7:0] cur_val;

    always @* begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        acc_addr = 6'h00;
        data_io = data_addr_i - `IOSP_DATA_OFFSET;
        if (io_wr_i || io_rd_i) begin
            acc_addr = io_addr_i;
            wr_en = io_wr_i;
            rd_en = io_rd_i;
        end else if ((load_op_i || memory_write_op_i) && data_addr_i >= `IOSP_DATA_OFFSET
                     && data_addr_i <= `IOSP_DATA_IO_END) begin
            acc_addr = data_io[5:0];
            wr_en = memory_write_op_i;
            rd_en = load_op_i;
        end else if (bit_set_op_i || bit_clear_op_i || skip_if_bit_set_i
                     || skip_if_bit_clear_i) begin
            acc_addr = {1'b0, bit_addr_i};
        end
        bit_op = (bit_set_op_i || bit_clear_op_i) && !io_wr_i && !io_rd_i
                 && !load_op_i && !memory_write_op_i;
        bit_mask = 8'h01 << bit_sel_i;
    end

    // Current register value, zero for reserved locations and bits.
    always @* begin
        if (acc_addr == `IOSP_PAD_LEVEL_B) cur_val = lvl_b;
        else if (acc_addr == `IOSP_DIRECTION_B) cur_val = direction_b_o;
        else if (acc_addr == `IOSP_DRIVE_LATCH_B) cur_val = drive_latch_b_o;
        else if (acc_addr == `IOSP_PAD_LEVEL_C) cur_val = lvl_c;
        else if (acc_addr == `IOSP_DIRECTION_C) cur_val = direction_c_o;
        else if (acc_addr == `IOSP_DRIVE_LATCH_C) cur_val = drive_latch_c_o;
        else if (acc_addr == `IOSP_PAD_LEVEL_D) cur_val = lvl_d;
        else if (acc_addr == `IOSP_DIRECTION_D) cur_val = direction_d_o;
        else if (acc_addr == `IOSP_DRIVE_LATCH_D) cur_val = drive_latch_d_o;
        else if (acc_addr == `IOSP_PAD_LEVEL_E) cur_val = lvl_e & `IOSP_MASK_E;
        else if (acc_addr == `IOSP_DIRECTION_E) cur_val = direction_e_o;
        else if (acc_addr == `IOSP_DRIVE_LATCH_E) cur_val = drive_latch_e_o;
        else if (acc_addr == `IOSP_TIMER0_FLAGS) cur_val = timer0_flags_o;
        else if (acc_addr == `IOSP_TIMER1_FLAGS) cur_val = timer1_flags_o;
        else if (acc_addr == `IOSP_SCRATCH_BYTE_1) cur_val = scratch_1;
        else if (acc_addr == `IOSP_SCRATCH_BYTE_2) cur_val = scratch_2;
        else if (acc_addr == `IOSP_PAD_CHANGE_FLAGS) cur_val = pad_change_flags_o;
        else cur_val = 8'h00;
    end

    // ----------------------------------------------------------------
    // Write data for plain and bit-wise accesses.
    // ----------------------------------------------------------------
    reg [7:0] next_val;
    reg [7:0] clr_t0;
    reg [7:0] clr_t1;
    reg [7:0] clr_pc;
    reg do_wr;

    always @* begin
        do_wr = wr_en || bit_op;
        if (bit_op && bit_set_op_i) next_val = cur_val | bit_mask;
        else if (bit_op) next_val = cur_val & ~bit_mask;
        else next_val = wdata_i;
        clr_t0 = 8'h00;
        clr_t1 = 8'h00;
        clr_pc = 8'h00;
        if (do_wr && acc_addr == `IOSP_TIMER0_FLAGS) begin
            clr_t0 = bit_op ? (bit_set_op_i ? bit_mask : 8'h00) : wdata_i;
        end
        if (do_wr && acc_addr == `IOSP_TIMER1_FLAGS) begin
            clr_t1 = bit_op ? (bit_set_op_i ? bit_mask : 8'h00) : wdata_i;
        end
        if (do_wr && acc_addr == `IOSP_PAD_CHANGE_FLAGS) begin
            clr_pc = bit_op ? (bit_set_op_i ? bit_mask : 8'h00) : wdata_i;
        end
    end

    // ----------------------------------------------------------------
    // Register storage.
    // ----------------------------------------------------------------
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            direction_b_o <= `IOSP_RESET_VALUE;
            drive_latch_b_o <= `IOSP_RESET_VALUE;
            direction_c_o <= `IOSP_RESET_VALUE;
            drive_latch_c_o <= `IOSP_RESET_VALUE;
            direction_d_o <= `IOSP_RESET_VALUE;
            drive_latch_d_o <= `IOSP_RESET_VALUE;
            direction_e_o <= `IOSP_RESET_VALUE;
            drive_latch_e_o <= `IOSP_RESET_VALUE;
            scratch_1 <= `IOSP_RESET_VALUE;
            scratch_2 <= `IOSP_RESET_VALUE;
            timer0_flags_o <= `IOSP_RESET_VALUE;
            timer1_flags_o <= `IOSP_RESET_VALUE;
            pad_change_flags_o <= `IOSP_RESET_VALUE;
        end else begin
            if (do_wr) begin
                if (acc_addr == `IOSP_DIRECTION_B) direction_b_o <= next_val;
                else if (acc_addr == `IOSP_DRIVE_LATCH_B) drive_latch_b_o <= next_val;
                else if (acc_addr == `IOSP_DIRECTION_C) direction_c_o <= next_val;
                else if (acc_addr == `IOSP_DRIVE_LATCH_C) drive_latch_c_o <= next_val;
                else if (acc_addr == `IOSP_DIRECTION_D) direction_d_o <= next_val;
                else if (acc_addr == `IOSP_DRIVE_LATCH_D) drive_latch_d_o <= next_val;
                else if (acc_addr == `IOSP_DIRECTION_E) direction_e_o <= next_val & `IOSP_MASK_E;
                else if (acc_addr == `IOSP_DRIVE_LATCH_E) drive_latch_e_o <= next_val & `IOSP_MASK_E;
                else if (acc_addr == `IOSP_SCRATCH_BYTE_1) scratch_1 <= next_val;
                else if (acc_addr == `IOSP_SCRATCH_BYTE_2) scratch_2 <= next_val;
            end
            // Hardware set wins over a software clear in the same cycle.
            timer0_flags_o <= ((timer0_flags_o & ~clr_t0) | timer0_set_i) & `IOSP_MASK_T0;
            timer1_flags_o <= ((timer1_flags_o & ~clr_t1) | timer1_set_i) & `IOSP_MASK_T1;
            pad_change_flags_o <= ((pad_change_flags_o & ~clr_pc) | pad_change_set_i)
                                  & `IOSP_MASK_PC;
        end
    end

    // ----------------------------------------------------------------
    // Read data, skip test and extended-region select.
    // ----------------------------------------------------------------
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_o <= 8'h00;
            skip_o <= 1'b0;
            ext_sel_o <= 1'b0;
        end else begin
            rdata_o <= rd_en ? cur_val : 8'h00;
            skip_o <= (skip_if_bit_set_i && (cur_val & bit_mask) != 8'h00)
                      || (skip_if_bit_clear_i && (cur_val & bit_mask) == 8'h00);
            ext_sel_o <= (load_op_i || memory_write_op_i)
                         && data_addr_i >= `IOSP_EXT_BASE;
        end
    end
endmodule // iosp_top

// ### src/iosp_consts.vh
// Constants for the low I/O register space decoder.
`ifndef IOSP_CONSTS_VH
`define IOSP_CONSTS_VH
`define IOSP_PAD_LEVEL_B 6'h03
`define IOSP_DIRECTION_B 6'h04
`define IOSP_DRIVE_LATCH_B 6'h05
`define IOSP_PAD_LEVEL_C 6'h06
`define IOSP_DIRECTION_C 6'h07
`define IOSP_DRIVE_LATCH_C 6'h08
`define IOSP_PAD_LEVEL_D 6'h09
`define IOSP_DIRECTION_D 6'h0a
`define IOSP_DRIVE_LATCH_D 6'h0b
`define IOSP_PAD_LEVEL_E 6'h0c
`define IOSP_DIRECTION_E 6'h0d
`define IOSP_DRIVE_LATCH_E 6'h0e
`define IOSP_TIMER0_FLAGS 6'h15
`define IOSP_TIMER1_FLAGS 6'h16
`define IOSP_SCRATCH_BYTE_1 6'h19
`define IOSP_SCRATCH_BYTE_2 6'h1a
`define IOSP_PAD_CHANGE_FLAGS 6'h1b
`define IOSP_BIT_LIMIT 6'h1f
`define IOSP_DATA_OFFSET 8'h20
`define IOSP_DATA_IO_END 8'h5f
`define IOSP_EXT_BASE 8'h60
`define IOSP_MASK_E 8'h07
`define IOSP_MASK_T0 8'h07
`define IOSP_MASK_T1 8'h27
`define IOSP_MASK_PC 8'h0f
`define IOSP_RESET_VALUE 8'h00
`endif

// ### src/iosp_sync.v
// Two-stage synchroniser for a bus of pad levels.
`timescale 1ns/1ps
module iosp_sync #(
    parameter WIDTH = 8
) (
    input wire clk_i,
    input wire rstn_i,
    input wire [WIDTH-1:0] async_i,
    output reg [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] stage1;
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stage1 <= {WIDTH{1'b0}};
            sync_o <= {WIDTH{1'b0}};
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end
endmodule // iosp_sync

// ### verification/iosp_core_model.sv
// Processor core model issuing one register access at a time.
`timescale 1ns/1ps
module iosp_core_model (
    input wire clk_i,
    output logic [7:0] stb_o = 8'h00,
    output logic [7:0] addr_o = 8'h00,
    output logic [7:0] wdata_o = 8'h00
);
    // Raises strobe k for one cycle; the strobe then returns to zero, address and data lines show the inverse value.
    task automatic op(input int k, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        stb_o = 8'h01 << k;
        addr_o = a;
        wdata_o = d;
        @(negedge clk_i);
        stb_o = 8'h00;
        addr_o = ~a;
        wdata_o = ~d;
    endtask
endmodule // iosp_core_model

// ### verification/iosp_top_asserts.sv
// Assertions on the ports of the low I/O register space.
`timescale 1ns/1ps
module iosp_chk (
    input wire clk_i,
    input wire rstn_i,
    input wire io_rd_i,
    input wire io_wr_i,
    input wire [5:0] io_addr_i,
    input wire load_op_i,
    input wire memory_write_op_i,
    input wire [7:0] data_addr_i,
    input wire bit_set_op_i,
    input wire [4:0] bit_addr_i,
    input wire [2:0] bit_sel_i,
    input wire [7:0] wdata_i,
    input wire [7:0] rdata_o,
    input wire ext_sel_o,
    input wire [7:0] direction_b_o,
    input wire [7:0] drive_latch_b_o,
    input wire [7:0] direction_e_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_bit; !load_op_i && !memory_write_op_i && !io_rd_i && !io_wr_i; endsequence
    property p_iw; io_wr_i && io_addr_i == 6'h04 |=> direction_b_o == $past(wdata_i); endproperty
    a_iw: assert property (p_iw) else $error("io write lost");
    property p_ld; load_op_i && data_addr_i == 8'h24 && !io_rd_i && !io_wr_i |=>
        rdata_o == $past(direction_b_o); endproperty
    a_ld: assert property (p_ld) else $error("load wrong");
    property p_st; memory_write_op_i && data_addr_i == 8'h24 && !io_rd_i && !io_wr_i |=>
        direction_b_o == $past(wdata_i); endproperty
    a_st: assert property (p_st) else $error("store lost");
    property p_ext; memory_write_op_i && data_addr_i >= 8'h60 && !io_rd_i && !io_wr_i |=>
        ext_sel_o && $stable(direction_b_o); endproperty
    a_ext: assert property (p_ext) else $error("extended store");
    property p_bset; bit_set_op_i && bit_addr_i == 5'h05 ##0 s_bit |=>
        drive_latch_b_o == ($past(drive_latch_b_o) | (8'h01 << $past(bit_sel_i))); endproperty
    a_bset: assert property (p_bset) else $error("bit set wrong");
    property p_rsv; io_rd_i && io_addr_i == 6'h11 |=> rdata_o == 8'h00; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved read");
    property p_ew; io_wr_i && io_addr_i == 6'h0d |=>
        direction_e_o == ($past(wdata_i) & 8'h07); endproperty
    a_ew: assert property (p_ew) else $error("port e write");
    property p_eb; direction_e_o[7:3] == 5'h00; endproperty
    a_eb: assert property (p_eb) else $error("port e bits");
endmodule // iosp_chk
bind iosp_top iosp_chk u_chk (
    .clk_i(clk_i), .rstn_i(rstn_i), .io_rd_i(io_rd_i), .io_wr_i(io_wr_i),
    .io_addr_i(io_addr_i), .load_op_i(load_op_i), .memory_write_op_i(memory_write_op_i),
    .data_addr_i(data_addr_i), .bit_set_op_i(bit_set_op_i), .bit_addr_i(bit_addr_i),
    .bit_sel_i(bit_sel_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .ext_sel_o(ext_sel_o),
    .direction_b_o(direction_b_o), .drive_latch_b_o(drive_latch_b_o),
    .direction_e_o(direction_e_o)
);

// ### verification/testbench.sv
// Self-checking testbench of the low I/O register space.
`timescale 1ns/1ps
module testbench;
    logic clk_i = 1'b0, rstn_i = 1'b0;
    logic [7:0] pad = 8'h3c, fs = 8'h00;
    wire [7:0] stb, addr, wd, rd, db, lb, de, t0, t1, pc, dc, lc, dd, ld, le;
    wire sk, ex;
    int num_errors = 0, cmp_count = 0;
    always #12.5 clk_i = ~clk_i;
    iosp_core_model u_cpu (.clk_i(clk_i), .stb_o(stb), .addr_o(addr), .wdata_o(wd));
    iosp_top u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .io_rd_i(stb[0]), .io_wr_i(stb[1]),
        .io_addr_i(addr[5:0]), .load_op_i(stb[2]), .memory_write_op_i(stb[3]),
        .data_addr_i(addr), .bit_set_op_i(stb[4]), .bit_clear_op_i(stb[5]),
        .skip_if_bit_set_i(stb[6]), .skip_if_bit_clear_i(stb[7]), .bit_addr_i(addr[4:0]),
        .bit_sel_i(wd[2:0]), .wdata_i(wd), .pad_b_i(pad), .pad_c_i(~pad), .pad_d_i(pad),
        .pad_e_i(pad[2:0]), .timer0_set_i(fs), .timer1_set_i(fs), .pad_change_set_i(fs),
        .rdata_o(rd), .skip_o(sk), .ext_sel_o(ex), .direction_b_o(db), .drive_latch_b_o(lb),
        .direction_c_o(dc), .drive_latch_c_o(lc), .direction_d_o(dd), .drive_latch_d_o(ld),
        .direction_e_o(de), .drive_latch_e_o(le), .timer0_flags_o(t0), .timer1_flags_o(t1),
        .pad_change_flags_o(pc));
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        cmp_count++;
        if (g !== e) $display("BAD %0t got %h exp %h", $time, g, e);
        if (g !== e) num_errors++;
    endtask
    task automatic end_sim;
        if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic t_rw;
        u_cpu.op(1, 8'h04, 8'h5a);
        u_cpu.op(3, 8'h24, 8'ha5);
        u_cpu.op(2, 8'h24, 8'h00);
        chk(rd, 8'ha5);
        u_cpu.op(3, 8'h64, 8'h00);
        chk({ex, db}, 24'h1a5);
    endtask
    task automatic t_bit;
        u_cpu.op(1, 8'h05, 8'h81);
        u_cpu.op(4, 8'h05, 8'h03);
        u_cpu.op(6, 8'h05, 8'h03);
        chk({sk, lb}, 24'h189);
        u_cpu.op(5, 8'h05, 8'h07);
        u_cpu.op(6, 8'h05, 8'h07);
        chk({sk, lb}, 24'h009);
        u_cpu.op(7, 8'h05, 8'h07);
        chk({sk, lb}, 24'h109);
    endtask
    task automatic t_flag;
        @(negedge clk_i) fs = 8'hff;
        @(negedge clk_i) fs = 8'h00;
        chk({pc, t1, t0}, 24'h0f2707);
        u_cpu.op(1, 8'h16, 8'h01);
        u_cpu.op(4, 8'h16, 8'h05);
        u_cpu.op(5, 8'h15, 8'h01);
        u_cpu.op(3, 8'h3b, 8'h05);
        chk({pc, t1, t0}, 24'h0a0607);
        fork
            u_cpu.op(1, 8'h15, 8'h01);
            begin
                @(negedge clk_i) fs = 8'h01;
                @(negedge clk_i) fs = 8'h00;
            end
        join
        chk({pc, t1, t0}, 24'h0b0707);
    endtask
    task automatic t_port;
        u_cpu.op(1, 8'h07, 8'h11);
        u_cpu.op(1, 8'h08, 8'h22);
        u_cpu.op(3, 8'h2a, 8'h33);
        u_cpu.op(3, 8'h2b, 8'h44);
        u_cpu.op(1, 8'h0e, 8'h05);
        chk({dc, lc, dd}, 24'h112233);
        chk({ld, le}, 24'h4405);
        u_cpu.op(1, 8'h19, 8'h5e);
        u_cpu.op(3, 8'h3a, 8'h96);
        u_cpu.op(0, 8'h19, 8'h00);
        chk(rd, 8'h5e);
        u_cpu.op(2, 8'h3a, 8'h00);
        chk(rd, 8'h96);
        u_cpu.op(0, 8'h03, 8'h00);
        chk(rd, 8'h3c);
        u_cpu.op(2, 8'h26, 8'h00);
        chk(rd, 8'hc3);
        u_cpu.op(0, 8'h09, 8'h00);
        chk(rd, 8'h3c);
    endtask
    task automatic t_rsv;
        u_cpu.op(1, 8'h11, 8'hff);
        u_cpu.op(0, 8'h11, 8'h00);
        chk(rd, 8'h00);
        u_cpu.op(1, 8'h0d, 8'hff);
        u_cpu.op(0, 8'h0c, 8'h00);
        chk({de, rd}, 24'h0704);
    endtask
    initial begin
        repeat (5) @(negedge clk_i);
        rstn_i = 1'b1;
        repeat (2) @(negedge clk_i);
        t_rw();
        t_bit();
        t_flag();
        t_rsv();
        t_port();
        end_sim();
    end
endmodule // testbench
